// >>> rtl/dcfg_pkg.sv
// Package of constants and types for the device configuration word loader.
`default_nettype none

package dcfg_pkg;

  // ----------------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_W = 32;
  localparam int unsigned CODE_PROT_BIT = 28;
  localparam int unsigned BOOT_PROT_BIT = 24;
  localparam int unsigned FLASH_PROT_MSB = 19;
  localparam int unsigned FLASH_PROT_LSB = 12;
  localparam int unsigned DBG_SEL_BIT = 3;
  localparam int unsigned DEBUG_MSB = 1;
  localparam int unsigned DEBUG_LSB = 0;
  // Reserved positions and the values they always carry.
  localparam logic [WORD_W-1:0] RSVD_MASK = 32'hEEF0_0FF4;
  localparam logic [WORD_W-1:0] RSVD_VALUE = 32'h6EF0_0FF4;
  // Word held before the load: every protection enabled.
  localparam logic [WORD_W-1:0] SAFE_WORD = RSVD_VALUE;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RAW = 8'h08;
  localparam int unsigned ST_LOADED = 0;
  localparam int unsigned ST_RSVD_ERR = 1;
  localparam int unsigned ST_PROG_DENY = 2;
  localparam int unsigned ST_BOOT_DENY = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [1:0] SETTLE_LAST = 2'h1;

  typedef struct packed {
    logic codeProtectN;
    logic bootFlashWriteProtectN;
    logic [7:0] programFlashProtectField;
    logic debugChannelSelect;
    logic [1:0] debugField;
  } settings_t;

  typedef enum logic [2:0] {
    LD_SETTLE = 3'h1,
    LD_LOAD = 3'h2,
    LD_HOLD = 3'h4
  } load_state_t;

  // Forces every reserved position to its fixed value.
  function automatic logic [WORD_W-1:0] fix_reserved(input logic [WORD_W-1:0] w);
    return (w & ~RSVD_MASK) | RSVD_VALUE;
  endfunction

  // Splits a configuration word into its programmable fields.
  function automatic settings_t decode_settings(input logic [WORD_W-1:0] w);
    settings_t s;
    s.codeProtectN = w[CODE_PROT_BIT];
    s.bootFlashWriteProtectN = w[BOOT_PROT_BIT];
    s.programFlashProtectField = w[FLASH_PROT_MSB:FLASH_PROT_LSB];
    s.debugChannelSelect = w[DBG_SEL_BIT];
    s.debugField = w[DEBUG_MSB:DEBUG_LSB];
    return s;
  endfunction

endpackage : dcfg_pkg

`default_nettype wire

// >>> rtl/cdc_sync.sv
// Two-stage synchroniser for a group of slow level inputs.
`default_nettype none

module cdc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [W-1:0] d, // Level from another domain.
  output logic [W-1:0] q // Synchronised level.
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule // cdc_sync

`default_nettype wire

// >>> rtl/device_config_word_zero.sv
// Loader and holder of the device configuration word, with an AXI4-Lite view.
`default_nettype none

// Summary of operation
// - Code-protect zero blocks external programmer access.
// - Boot write-protect zero blocks runtime boot writes.
// - Word holds protect, select and debug fields.
// - Reserved bits read back fixed values from the config register; the raw register shows them as stored.
module device_config_word_zero (
  input wire logic clk, // System clock, 20 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [31:0] nvWord, // Stored configuration word from the array.
  input wire logic progAccessReq, // External programmer asks for flash access.
  output logic progAccessGrant, // Programmer access allowed.
  input wire logic bootWriteReq, // Flash controller asks to write boot flash.
  output logic bootWriteGrant, // Boot flash write allowed.
  output dcfg_pkg::settings_t settings, // Held settings for flash and debug.
  output logic configLoaded, // Settings are valid.
  input wire logic [7:0] awaddr, // AXI write address.
  input wire logic awvalid, // AXI write address valid.
  output logic awready, // AXI write address ready.
  input wire logic [31:0] wdata, // AXI write data.
  input wire logic [3:0] wstrb, // AXI write strobes.
  input wire logic wvalid, // AXI write data valid.
  output logic wready, // AXI write data ready.
  output logic [1:0] bresp, // AXI write response.
  output logic bvalid, // AXI write response valid.
  input wire logic bready, // AXI write response ready.
  input wire logic [7:0] araddr, // AXI read address.
  input wire logic arvalid, // AXI read address valid.
  output logic arready, // AXI read address ready.
  output logic [31:0] rdata, // AXI read data.
  output logic [1:0] rresp, // AXI read response.
  output logic rvalid, // AXI read data valid.
  input wire logic rready // AXI read data ready.
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [32:0] syncIn;
  logic [31:0] wordSync;
  logic progReqSync;

  cdc_sync #(.W(33)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({progAccessReq, nvWord}),
    .q(syncIn)
  );

  assign wordSync = syncIn[31:0];
  assign progReqSync = syncIn[32];

  // ----------------------------------------------------------------------
  // Load sequence
  // ----------------------------------------------------------------------
  dcfg_pkg::load_state_t state_q;
  logic [1:0] settle_q;
  logic loaded_q;
  logic [31:0] heldWord_q;
  logic [31:0] rawWord_q;
  logic rsvdErr_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dcfg_pkg::LD_SETTLE;
      settle_q <= 2'h0;
    end else begin
      case (state_q)
        dcfg_pkg::LD_SETTLE: begin
          if (settle_q == dcfg_pkg::SETTLE_LAST) begin
            state_q <= dcfg_pkg::LD_LOAD;
          end else begin
            settle_q <= settle_q + 2'h1;
          end
        end
        dcfg_pkg::LD_LOAD: begin
          state_q <= dcfg_pkg::LD_HOLD;
        end
        dcfg_pkg::LD_HOLD: begin
          state_q <= dcfg_pkg::LD_HOLD;
        end
        default: begin
          state_q <= dcfg_pkg::LD_SETTLE;
        end
      endcase
    end
  end

  // The word is taken once; nothing but reset can change it afterwards.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      heldWord_q <= dcfg_pkg::SAFE_WORD;
      rawWord_q <= '0;
      loaded_q <= 1'b0;
      rsvdErr_q <= 1'b0;
    end else if (state_q == dcfg_pkg::LD_LOAD) begin
      heldWord_q <= dcfg_pkg::fix_reserved(wordSync);
      rawWord_q <= wordSync;
      loaded_q <= 1'b1;
      // A word whose reserved bits were programmed wrongly is flagged.
      rsvdErr_q <= (wordSync & dcfg_pkg::RSVD_MASK) != dcfg_pkg::RSVD_VALUE;
    end
  end

  assign settings = dcfg_pkg::decode_settings(heldWord_q);
  assign configLoaded = loaded_q;

  // ----------------------------------------------------------------------
  // Access gating
  // ----------------------------------------------------------------------
  logic progDenyEvt;
  logic bootDenyEvt;

  assign progAccessGrant = progReqSync && loaded_q && settings.codeProtectN;
  assign bootWriteGrant = bootWriteReq && loaded_q && settings.bootFlashWriteProtectN;
  assign progDenyEvt = progReqSync && !progAccessGrant;
  assign bootDenyEvt = bootWriteReq && !bootWriteGrant;

  // ----------------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------------
  logic awHeld_q;
  logic wHeld_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wrFire;
  logic clrProg;
  logic clrBoot;
  logic progDeny_q;
  logic bootDeny_q;

  // Answer for a register access; only the status word takes writes.
  function automatic logic [1:0] access_resp(input logic [7:0] a, input logic isWrite);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    if (w == dcfg_pkg::OFF_STATUS) begin
      return dcfg_pkg::RESP_OKAY;
    end
    if (w == dcfg_pkg::OFF_CONFIG || w == dcfg_pkg::OFF_RAW) begin
      return isWrite ? dcfg_pkg::RESP_SLVERR : dcfg_pkg::RESP_OKAY;
    end
    return dcfg_pkg::RESP_DECERR;
  endfunction

  assign awready = !awHeld_q && !bvalid_q;
  assign wready = !wHeld_q && !bvalid_q;
  assign wrFire = awHeld_q && wHeld_q && !bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
    end else if (awvalid && awready) begin
      awHeld_q <= 1'b1;
      awAddr_q <= awaddr;
    end else if (wrFire) begin
      awHeld_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wHeld_q <= 1'b0;
      wData_q <= '0;
      wStrb_q <= '0;
    end else if (wvalid && wready) begin
      wHeld_q <= 1'b1;
      wData_q <= wdata;
      wStrb_q <= wstrb;
    end else if (wrFire) begin
      wHeld_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= dcfg_pkg::RESP_OKAY;
    end else if (wrFire) begin
      bvalid_q <= 1'b1;
      bresp_q <= access_resp(awAddr_q, 1'b1);
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Writing a one clears a deny flag; a new denial in that cycle wins.
  assign clrProg = wrFire && access_resp(awAddr_q, 1'b1) == dcfg_pkg::RESP_OKAY
                   && wStrb_q[0] && wData_q[dcfg_pkg::ST_PROG_DENY];
  assign clrBoot = wrFire && access_resp(awAddr_q, 1'b1) == dcfg_pkg::RESP_OKAY
                   && wStrb_q[0] && wData_q[dcfg_pkg::ST_BOOT_DENY];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      progDeny_q <= 1'b0;
      bootDeny_q <= 1'b0;
    end else begin
      progDeny_q <= progDenyEvt || (progDeny_q && !clrProg);
      bootDeny_q <= bootDenyEvt || (bootDeny_q && !clrBoot);
    end
  end

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] statusWord;

  always_comb begin
    statusWord = '0;
    statusWord[dcfg_pkg::ST_LOADED] = loaded_q;
    statusWord[dcfg_pkg::ST_RSVD_ERR] = rsvdErr_q;
    statusWord[dcfg_pkg::ST_PROG_DENY] = progDeny_q;
    statusWord[dcfg_pkg::ST_BOOT_DENY] = bootDeny_q;
  end

  function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [31:0] cfg,
                                           input logic [31:0] st, input logic [31:0] raw);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    if (w == dcfg_pkg::OFF_CONFIG) begin
      return cfg;
    end
    if (w == dcfg_pkg::OFF_STATUS) begin
      return st;
    end
    if (w == dcfg_pkg::OFF_RAW) begin
      return raw;
    end
    return '0;
  endfunction

  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= dcfg_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= read_mux(araddr, heldWord_q, statusWord, rawWord_q);
      rresp_q <= access_resp(araddr, 1'b0);
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [2:0] sinceRst_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sinceRst_q <= 3'h0;
    end else if (sinceRst_q != 3'h7) begin
      sinceRst_q <= sinceRst_q + 3'h1;
    end
  end

  property p_prog_blocked;
    progReqSync && !heldWord_q[dcfg_pkg::CODE_PROT_BIT] |-> !progAccessGrant ##1 progDeny_q;
  endproperty
  a_prog_blocked: assert property (p_prog_blocked) else $error("programmer not blocked");

  property p_prog_allowed;
    loaded_q && progReqSync && heldWord_q[dcfg_pkg::CODE_PROT_BIT] |-> progAccessGrant;
  endproperty
  a_prog_allowed: assert property (p_prog_allowed) else $error("programmer wrongly denied");

  property p_boot_gate;
    bootWriteGrant |-> bootWriteReq && heldWord_q[dcfg_pkg::BOOT_PROT_BIT] && loaded_q;
  endproperty
  a_boot_gate: assert property (p_boot_gate) else $error("boot write not gated");

  property p_boot_deny;
    bootWriteReq && !settings.bootFlashWriteProtectN |=> bootDeny_q;
  endproperty
  a_boot_deny: assert property (p_boot_deny) else $error("boot denial not flagged");

  property p_fields;
    $rose(loaded_q) |-> settings.programFlashProtectField
                        == $past(wordSync[dcfg_pkg::FLASH_PROT_MSB:dcfg_pkg::FLASH_PROT_LSB])
                        && settings.debugField == $past(wordSync[1:0]);
  endproperty
  a_fields: assert property (p_fields) else $error("fields not taken from word");

  property p_reserved;
    arvalid && arready && araddr == dcfg_pkg::OFF_CONFIG
      |=> (rdata & dcfg_pkg::RSVD_MASK) == dcfg_pkg::RSVD_VALUE;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read wrong");

  property p_load_time;
    $rose(loaded_q) |-> sinceRst_q == 3'h3;
  endproperty
  a_load_time: assert property (p_load_time) else $error("load at wrong cycle");

  property p_hold;
    loaded_q |=> (loaded_q && $stable(heldWord_q)) [*4];
  endproperty
  a_hold: assert property (p_hold) else $error("held word changed");

  property p_read_latency;
    arvalid && arready |=> rvalid;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read answer late");

  c_loaded: cover property ($rose(loaded_q));
  c_prog_grant: cover property (progAccessGrant);
  c_boot_denied: cover property (bootDenyEvt && loaded_q);
  c_status_clear: cover property (clrProg || clrBoot);

endmodule // device_config_word_zero

`default_nettype wire

// >>> testbench/flash_side_model.sv
// Model of the programmer, flash array and flash controller that face the loader.
`default_nettype none

module flash_side_model (
  input wire logic [31:0] fieldWord, // Programmable field values to store.
  input wire logic badReserved, // Stores a wrong reserved bit 31 when set.
  input wire logic progWant, // Programmer wants flash access.
  input wire logic bootWant, // Controller wants a boot flash write.
  output logic [31:0] nvWord, // Word held in the array.
  output logic progAccessReq, // Programmer access request.
  output logic bootWriteReq // Boot flash write request.
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Stored word
  // ----------------------------------------------------------------------
  // The programmer fills every reserved position with its fixed value unless told otherwise.
  assign nvWord = ((fieldWord & ~dcfg_pkg::RSVD_MASK) | dcfg_pkg::RSVD_VALUE)
                  ^ {badReserved, 31'h0};
  assign progAccessReq = progWant;
  assign bootWriteReq = bootWant;
endmodule // flash_side_model

`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking testbench of the configuration word loader.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] fieldWord = 32'h0000_0000;
  logic badReserved = 1'b0;
  logic progWant = 1'b0;
  logic bootWant = 1'b0;
  wire logic [31:0] nvWord;
  wire logic progAccessReq;
  wire logic bootWriteReq;
  logic progAccessGrant, bootWriteGrant, configLoaded;
  dcfg_pkg::settings_t settings;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] rdExp[$];
  logic [1:0] wrExp[$];
  int fails = 0;
  int nCompared = 0;
  int cyc = 0;

  always #25 clk = ~clk;

  flash_side_model flash_side_model_i (.fieldWord(fieldWord), .badReserved(badReserved),
    .progWant(progWant), .bootWant(bootWant), .nvWord(nvWord),
    .progAccessReq(progAccessReq), .bootWriteReq(bootWriteReq));

  device_config_word_zero device_config_word_zero_i (.clk(clk), .rst_n(rst_n),
    .nvWord(nvWord), .progAccessReq(progAccessReq), .progAccessGrant(progAccessGrant),
    .bootWriteReq(bootWriteReq), .bootWriteGrant(bootWriteGrant), .settings(settings),
    .configLoaded(configLoaded), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic stopTest();
    if (fails == 0 && nCompared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] expSet(input logic [31:0] v);
    return {19'h0, v[28], v[24], v[19:12], v[3], v[1:0]};
  endfunction

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
    @(posedge clk);
    wrExp.push_back(er);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    rdExp.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // Response monitor and watchdog
  // ----------------------------------------------------------------------
  always @(posedge clk) begin : monitor
    logic [33:0] e;
    if (rvalid === 1'b1 && rready === 1'b1) begin
      e = rdExp.pop_front();
      check({30'h0, rresp}, {30'h0, e[33:32]});
      check(rdata, e[31:0]);
    end
    if (bvalid === 1'b1 && bready === 1'b1) check({30'h0, bresp}, {30'h0, wrExp.pop_front()});
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      stopTest();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] w, f, fw;
    logic rsvdErr;
    void'($urandom(32'h0000_22c7));
    for (int i = 0; i < 4; i++) begin
      f = $urandom();
      f[28] = i[0];
      f[24] = i[1];
      w = (f & ~dcfg_pkg::RSVD_MASK) | dcfg_pkg::RSVD_VALUE;
      if (i == 3) w[31] = 1'b1;
      fw = (w & ~dcfg_pkg::RSVD_MASK) | dcfg_pkg::RSVD_VALUE;
      rsvdErr = ((w & dcfg_pkg::RSVD_MASK) !== dcfg_pkg::RSVD_VALUE);
      @(posedge clk);
      rst_n <= 1'b0;
      fieldWord <= f;
      badReserved <= (i == 3);
      repeat (4) @(posedge clk);
      @(negedge clk);
      check({31'h0, configLoaded}, 32'h0000_0000);
      check({19'h0, settings}, expSet(dcfg_pkg::SAFE_WORD));
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check({31'h0, configLoaded}, 32'h0000_0000);
      @(negedge clk);
      check({31'h0, configLoaded}, 32'h0000_0001);
      check({19'h0, settings}, expSet(w));
      axiRead(dcfg_pkg::OFF_CONFIG, fw, dcfg_pkg::RESP_OKAY);
      axiRead(dcfg_pkg::OFF_RAW, w, dcfg_pkg::RESP_OKAY);
      axiRead(dcfg_pkg::OFF_STATUS, {30'h0, rsvdErr, 1'b1}, dcfg_pkg::RESP_OKAY);
      @(posedge clk);
      bootWant <= 1'b1;
      progWant <= 1'b1;
      @(negedge clk);
      check({31'h0, bootWriteGrant}, {31'h0, w[24]});
      repeat (2) @(negedge clk);
      check({31'h0, progAccessGrant}, {31'h0, w[28]});
      @(posedge clk);
      bootWant <= 1'b0;
      progWant <= 1'b0;
      @(negedge clk);
      check({31'h0, bootWriteGrant}, 32'h0000_0000);
      axiRead(dcfg_pkg::OFF_STATUS, {28'h0, ~w[24], ~w[28], rsvdErr, 1'b1},
              dcfg_pkg::RESP_OKAY);
      axiWrite(dcfg_pkg::OFF_STATUS, 32'h0000_000C, 4'h1, dcfg_pkg::RESP_OKAY);
      axiRead(dcfg_pkg::OFF_STATUS, {30'h0, rsvdErr, 1'b1}, dcfg_pkg::RESP_OKAY);
      axiWrite(dcfg_pkg::OFF_CONFIG, ~w, 4'hF, dcfg_pkg::RESP_SLVERR);
      axiWrite(8'h10, w, 4'hF, dcfg_pkg::RESP_DECERR);
      axiRead(8'h10, 32'h0000_0000, dcfg_pkg::RESP_DECERR);
      // A later change of the stored word must not reach the held settings.
      @(posedge clk);
      fieldWord <= ~f;
      repeat (4) @(negedge clk);
      check({19'h0, settings}, expSet(w));
      axiRead(dcfg_pkg::OFF_CONFIG, fw, dcfg_pkg::RESP_OKAY);
      axiRead(dcfg_pkg::OFF_RAW, w, dcfg_pkg::RESP_OKAY);
    end
    repeat (2) @(posedge clk);
    stopTest();
  end
endmodule // tb_top

`default_nettype wire
